// ---- rtl/rfd_regfile.sv ----
`timescale 1ns/100ps
// Contract
// - 128 entries of 132 bits, one read and one write port, concurrent.
// - access inputs registered (scan enable, write inhibit, clock gate and scan controls act unregistered); read data held in an output flop.
// - read enable: registered address read in phase one, data out.
// - write enable: write data stored at write address in phase two.
// - separate enables decode read, write, or both together.
// - write alone performs only the write; read port idle.
// - model drives read output unknown on same-entry read and write.
// - array tolerates same-entry read and write without damage.
// - one read and one write every cycle at rated clock.
// - input flops chained from scan in to scan out.
module rfd_regfile #(
	parameter int ENTRIES = rfd_pkg::ENTRIES,
	parameter int DATA_W = rfd_pkg::DATA_W,
	parameter int ADDR_W = rfd_pkg::ADDR_W
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [ADDR_W-1:0] i_rd_addr,
	input wire logic i_rd_en,
	input wire logic [ADDR_W-1:0] i_wr_addr,
	input wire logic i_wr_en,
	input wire logic [DATA_W-1:0] i_din,
	input wire logic i_scan_in,
	input wire logic i_scan_en,
	input wire logic i_scan_in_clk_en,
	input wire logic i_scan_out_clk_en,
	input wire logic i_test_input_collar_hold,
	input wire logic i_test_clock_gate_override,
	input wire logic i_clk_gate_en,
	input wire logic i_wr_inhibit,
	output logic [DATA_W-1:0] o_dout,
	output logic o_scan_out
);
	if (ENTRIES < 2 || ENTRIES > (1 << ADDR_W) || DATA_W < 1)
	begin : geom_chk
		$error("rfd_regfile: unsupported geometry");
	end

	// ============================================================
	// input capture and scan chain
	localparam int CHAIN_W = 2 * ADDR_W + 2 + DATA_W;
	logic [CHAIN_W-1:0] chain_q;
	logic [CHAIN_W-1:0] chain_d;
	logic scan_last_q;
	logic scan_last_d;
	logic clk_on;

	// outside scan, a gated-off clock header freezes the input stage, override forces it on
	assign clk_on = i_clk_gate_en | i_test_clock_gate_override;

	always_comb
	begin
		chain_d = chain_q;
		scan_last_d = scan_last_q;
		if (i_scan_en)
		begin
			// shift one place per scan-in enable; collar hold freezes the input end
			if (i_scan_in_clk_en)
				chain_d = {chain_q[CHAIN_W-2:0],
					i_test_input_collar_hold ? chain_q[0] : i_scan_in};
			if (i_scan_out_clk_en)
				scan_last_d = chain_q[CHAIN_W-1];
		end
		else if (clk_on)
		begin
			chain_d = {i_rd_addr, i_rd_en, i_wr_addr, i_wr_en, i_din};
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			chain_q <= '0;
			scan_last_q <= 1'b0;
		end
		else
		begin
			chain_q <= chain_d;
			scan_last_q <= scan_last_d;
		end
	end

	assign o_scan_out = scan_last_q;

	// ============================================================
	// decode of the registered request
	logic [ADDR_W-1:0] rd_addr_r;
	logic [ADDR_W-1:0] wr_addr_r;
	logic rd_en_r;
	logic wr_en_r;
	logic [DATA_W-1:0] din_r;
	logic active;
	rfd_pkg::rfd_op_t op;

	assign {rd_addr_r, rd_en_r, wr_addr_r, wr_en_r, din_r} = chain_q;
	// scanning or inhibit turns every access into a no-op
	assign active = !i_scan_en && !i_wr_inhibit;
	assign op = active ? rfd_pkg::rfd_op_t'({wr_en_r, rd_en_r}) : rfd_pkg::RFD_IDLE;

	// both access kinds that drive the write port in phase two
	function automatic logic is_write(input rfd_pkg::rfd_op_t kind);
		return (kind == rfd_pkg::RFD_WR) || (kind == rfd_pkg::RFD_RW);
	endfunction

	// ============================================================
	// storage, read phase one then write phase two
	// no reset on the array: too large, and content before a write is meaningless
	logic [DATA_W-1:0] mem_q [ENTRIES];
	logic [DATA_W-1:0] dout_q;
	logic [DATA_W-1:0] dout_d;
	logic collide;
	logic wr_do;
	logic [ADDR_W-1:0] wr_idx;
	logic [DATA_W-1:0] wr_data;

	assign collide = (op == rfd_pkg::RFD_RW) && (rd_addr_r == wr_addr_r);

	// write request settled here so the flop only registers it
	always_comb
	begin
		wr_do = is_write(op);
		wr_idx = wr_addr_r;
		wr_data = din_r;
	end

	always_comb
	begin
		dout_d = dout_q;
		unique case (op)
			rfd_pkg::RFD_RD:
				dout_d = mem_q[rd_addr_r];
			rfd_pkg::RFD_RW:
				// array survives it; only the model reports unknown
				dout_d = collide ? {DATA_W{1'bx}} : mem_q[rd_addr_r];
			rfd_pkg::RFD_WR,
			rfd_pkg::RFD_IDLE:
				dout_d = dout_q;
		endcase
	end

	// read sees old contents since both happen on one edge
	always_ff @(posedge i_clk)
	begin
		dout_q <= dout_d;
		if (wr_do)
			mem_q[wr_idx] <= wr_data;
	end

	// consumer flops this after its own logic
	assign o_dout = dout_q;

	// ============================================================
	// checks
	logic [DATA_W-1:0] shadow_q;
	logic [DATA_W-1:0] shadow_d;

	// last plain write data, so the store check need not look back into the array
	always_comb
	begin
		shadow_d = shadow_q;
		if (op == rfd_pkg::RFD_WR)
			shadow_d = din_r;
	end

	always_ff @(posedge i_clk)
	begin
		shadow_q <= shadow_d;
	end

	// output is unknown until the first read, so holds compare with case equality
	rd_data_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(op == rfd_pkg::RFD_RD) |=> (o_dout == $past(mem_q[rd_addr_r])))
		else $error("read data mismatch");
	idle_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(op == rfd_pkg::RFD_IDLE) |=> (o_dout === $past(o_dout)))
		else $error("output moved without read");
	wr_only_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(op == rfd_pkg::RFD_WR) |=> (o_dout === $past(o_dout)))
		else $error("write disturbed read port");
	wr_store_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(op == rfd_pkg::RFD_WR) |=> (mem_q[$past(wr_addr_r)] == shadow_q))
		else $error("write not stored");
	rw_both_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(op == rfd_pkg::RFD_RW && !collide) |=> (o_dout == $past(mem_q[rd_addr_r])))
		else $error("concurrent read lost");
	rw_store_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(op == rfd_pkg::RFD_RW && !collide) |=> (mem_q[$past(wr_addr_r)] == $past(din_r)))
		else $error("concurrent write lost");
	coll_store_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		collide |=> (mem_q[$past(wr_addr_r)] == $past(din_r)))
		else $error("write lost on collision");
	in_capture_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(!i_scan_en && clk_on) |=> (rd_addr_r == $past(i_rd_addr) && wr_en_r == $past(i_wr_en)))
		else $error("inputs not registered");
	din_capture_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(!i_scan_en && clk_on)
		|=> (din_r == $past(i_din) && wr_addr_r == $past(i_wr_addr) && rd_en_r == $past(i_rd_en)))
		else $error("data inputs not registered");
	gate_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(!i_scan_en && !clk_on) |=> $stable(chain_q))
		else $error("input stage moved while gated");
	inhibit_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_wr_inhibit |=> (o_dout === $past(o_dout)))
		else $error("output moved under inhibit");
	scan_noacc_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		i_scan_en |=> (o_dout === $past(o_dout)))
		else $error("access during scan");
	scan_shift_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_scan_en && i_scan_in_clk_en && !i_test_input_collar_hold)
		|=> (chain_q[0] == $past(i_scan_in)))
		else $error("scan shift broken");
	collar_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_scan_en && i_scan_in_clk_en && i_test_input_collar_hold)
		|=> (chain_q[0] == $past(chain_q[0])))
		else $error("collar hold ignored");
	scan_out_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_scan_en && i_scan_out_clk_en) |=> (o_scan_out == $past(chain_q[CHAIN_W-1])))
		else $error("scan out broken");
endmodule // rfd_regfile

// ---- inc/rfd_pkg.sv ----
package rfd_pkg;
	// ============================================================
	// array geometry
	localparam int ENTRIES = 128;
	localparam int DATA_W = 132;
	localparam int ADDR_W = 7;
	// ============================================================
	// timing
	localparam int CLK_MHZ = 25;
	localparam int RATED_MHZ = 375;
	localparam int ACCESS_CYCLES = 1;
	// ============================================================
	// decoded access kinds
	typedef enum logic [1:0] {
		RFD_IDLE = 2'b00,
		RFD_RD = 2'b01,
		RFD_WR = 2'b10,
		RFD_RW = 2'b11
	} rfd_op_t;
endpackage

// ---- verif/rfd_consumer.sv ----
`timescale 1ns/100ps
module rfd_consumer (
	input wire logic i_clk,
	input wire logic [rfd_pkg::DATA_W-1:0] i_dout,
	output logic [rfd_pkg::DATA_W-1:0] o_cap
);
	// ============================================================
	// capture after outside logic; inverting every bit keeps the path real
	always_ff @(posedge i_clk)
		o_cap <= ~i_dout;
endmodule // rfd_consumer

// ---- verif/test_rfd_regfile.sv ----
`timescale 1ns/100ps
module test_rfd_regfile;
	logic i_clk = 0, i_resetn = 0, re = 0, we = 0, ge = 1, inh = 0;
	logic si = 0, se = 0, sck = 0, hold = 0;
	logic so;
	logic [6:0] ra = 7'h00, wa = 7'h00;
	logic [131:0] din = '0, dout, cap;
	int failures = 0, cmp_count = 0;
	always #20 i_clk = ~i_clk;
	rfd_regfile i_rfd_regfile (.i_clk(i_clk), .i_resetn(i_resetn), .i_rd_addr(ra),
		.i_rd_en(re), .i_wr_addr(wa), .i_wr_en(we), .i_din(din), .i_scan_in(si),
		.i_scan_en(se), .i_scan_in_clk_en(sck), .i_scan_out_clk_en(sck),
		.i_test_input_collar_hold(hold), .i_test_clock_gate_override(1'b0),
		.i_clk_gate_en(ge), .i_wr_inhibit(inh), .o_dout(dout), .o_scan_out(so));
	rfd_consumer i_rfd_consumer (.i_clk(i_clk), .i_dout(dout), .o_cap(cap));
	// ============================================================
	// helpers
	task automatic chk(input logic [131:0] e, input logic [131:0] g);
		cmp_count++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// inputs captured one edge after being set, access lands on the next
	task automatic op(input logic r, input logic [6:0] a, input logic w,
		input logic [6:0] b, input logic [131:0] d);
		@(posedge i_clk);
		#1 {re, ra, we, wa, din} = {r, a, w, b, d};
		@(posedge i_clk);
		#1 {re, we} = 2'b00;
		@(posedge i_clk);
		#1;
	endtask
	// ============================================================
	// scenarios
	task automatic t_basic;
		op(0, 0, 1, 7'h00, {33{4'ha}});
		op(0, 0, 1, 7'h7f, {33{4'h5}});
		op(1, 7'h00, 0, 0, 0);
		chk({33{4'ha}}, dout);
		op(1, 7'h7f, 0, 0, 0);
		chk({33{4'h5}}, dout);
	endtask
	task automatic t_both;
		op(1, 7'h00, 1, 7'h7f, {33{4'hc}});
		chk({33{4'ha}}, dout);
		op(1, 7'h7f, 0, 0, 0);
		chk({33{4'hc}}, dout);
	endtask
	task automatic t_hold;
		op(0, 0, 0, 0, 0);
		chk({33{4'hc}}, dout);
		op(0, 0, 1, 7'h00, {33{4'h3}});
		chk({33{4'hc}}, dout);
		chk({33{4'h3}}, cap);
		op(1, 7'h00, 0, 0, 0);
		chk({33{4'h3}}, dout);
	endtask
	// refused accesses: inhibit, then gated capture
	task automatic t_refuse;
		inh = 1;
		op(1, 7'h7f, 1, 7'h00, {33{4'he}});
		inh = 0;
		chk({33{4'h3}}, dout);
		ge = 0;
		op(0, 0, 1, 7'h00, {33{4'h9}});
		ge = 1;
		op(1, 7'h00, 0, 0, 0);
		chk({33{4'h3}}, dout);
	endtask
	task automatic t_coll;
		op(1, 7'h05, 1, 7'h05, {33{4'h6}});
		chk({132{1'bx}}, dout);
		op(1, 7'h05, 0, 0, 0);
		chk({33{4'h6}}, dout);
	endtask
	// scan: flush, three shifts under collar hold, then time one marker bit out
	task automatic t_scan;
		int n;
		op(0, 0, 0, 0, 0);
		{se, sck, hold, si} = 4'hf;
		repeat (3) @(posedge i_clk);
		#1 hold = 0;
		@(posedge i_clk);
		#1 si = 0;
		n = 0;
		while (!so && n < 200)
		begin
			@(posedge i_clk);
			#1 n++;
		end
		chk(132'(2 * rfd_pkg::ADDR_W + 2 + rfd_pkg::DATA_W), 132'(n));
		@(posedge i_clk);
		#1 {se, sck} = 2'b00;
		chk('0, 132'(so));
		@(posedge i_clk);
		@(posedge i_clk);
		#1 chk({33{4'h6}}, dout);
	endtask
	// ============================================================
	// verdict
	task automatic stop_test;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge i_clk);
		#1 i_resetn = 1;
		t_basic();
		t_both();
		t_hold();
		t_refuse();
		t_coll();
		t_scan();
		stop_test();
	end
endmodule // test_rfd_regfile
